// ===== core/bst_regs.svh
// register offsets, field positions, reset values and chain positions
`ifndef BST_REGS_SVH
`define BST_REGS_SVH

// register byte offsets
`define BST_CTRL_OFS        8'h00
`define BST_STATUS_OFS      8'h04
`define BST_DATA_OFS        8'h08

// field positions
`define BST_CTRL_CAP_EN_BIT 0
`define BST_STAT_MODE_LSB   0
`define BST_STAT_OVF_BIT    2
`define BST_STAT_LVL_LSB    8

// reset values
`define BST_CTRL_RST        32'h0000_0000
`define BST_CHAIN_RST       127'h0

// chain length and positions, counted from 1 at the serial input
`define BST_CHAIN_LEN       127
`define BST_POS_SIN         1
`define BST_POS_SEL         2
`define BST_POS_SHIFT       3
`define BST_POS_RESET       4
`define BST_POS_DATA_CTL    5
`define BST_POS_D0          6
`define BST_POS_D63         69
`define BST_POS_CC1         70
`define BST_POS_CC0         71
`define BST_POS_A31         72
`define BST_POS_A3          100
`define BST_POS_ADDR_CTL    101
`define BST_POS_ROW_CTL     102
`define BST_POS_ROW         103
`define BST_POS_PAGE_CTL    104
`define BST_POS_PAGE        105
`define BST_POS_DIR_CTL     106
`define BST_POS_DIR         107
`define BST_POS_STB_CTL     108
`define BST_POS_STB         109
`define BST_POS_HOLD_ACK    110
`define BST_POS_LOCK_CTL    111
`define BST_POS_LOCK        112
`define BST_POS_READY_IN    113
`define BST_POS_CACHE_IN    114
`define BST_POS_NEXT_IN     115
`define BST_POS_INT_IN      116
`define BST_POS_HOLD_IN     117
`define BST_POS_BE_CTL      118
`define BST_POS_BE_HIGH     119
`define BST_POS_BE_LOW      126
`define BST_POS_BUS_REQUEST_SERIAL_OUT        127

`endif

// ===== core/bst_pkg.sv
// types shared by the boundary scan test port
package bst_pkg;

	// test mode of the port
	typedef enum logic [1:0] {
		BST_NONE   = 2'b00,
		BST_NORMAL = 2'b01,
		BST_SHIFT  = 2'b10
	} bst_mode_t;

	// level and enable of every chain pin, bit i is chain position i+1
	typedef struct packed {
		logic [126:0] lvl;
		logic [126:0] oe;
	} bst_pins_t;

	// one ahb-lite address phase held into the data phase
	typedef struct packed {
		logic       rd;
		logic       wr;
		logic [7:0] addr;
	} bst_aphase_t;

endpackage : bst_pkg

// ===== core/bst_sync.sv
// two flip-flop synchroniser for a bundle of pin levels
`timescale 1ns/10ps
`default_nettype none

module bst_sync #(
	parameter int WIDTH = 127
) (
	input  wire logic             hclk,    // processor clock
	input  wire logic             hresetn, // async reset, active low
	input  wire logic [WIDTH-1:0] d_in,    // asynchronous levels
	output logic      [WIDTH-1:0] q_out    // synchronised levels
);

	logic [WIDTH-1:0] meta_r;

	// first stage is read only by the second stage
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			meta_r <= '0;
			q_out  <= '0;
		end else begin
			meta_r <= d_in;
			q_out  <= meta_r;
		end
	end

endmodule : bst_sync

`default_nettype wire

// ===== core/bst_fifo.sv
// synchronous fifo with valid and ready on both sides
`timescale 1ns/10ps
`default_nettype none

module bst_fifo #(
	parameter int WIDTH = 32,
	parameter int DEPTH = 32,
	parameter int AW    = $clog2(DEPTH)
) (
	input  wire logic             hclk,      // clock
	input  wire logic             hresetn,   // async reset, active low
	input  wire logic             in_valid,  // write request
	output logic                  in_ready,  // room for a word
	input  wire logic [WIDTH-1:0] in_data,   // word to store
	output logic                  out_valid, // word available
	input  wire logic             out_ready, // reader takes head
	output logic      [WIDTH-1:0] out_data,  // head word
	output logic      [AW:0]      level      // words held
);

	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0]    wr_ptr_r;
	logic [AW-1:0]    rd_ptr_r;
	logic [AW:0]      cnt_r;
	wire              push = in_valid && in_ready;
	wire              pop  = out_valid && out_ready;

	// honest full and empty from the word count
	assign in_ready  = (cnt_r != (AW+1)'(DEPTH));
	assign out_valid = (cnt_r != '0);
	assign out_data  = mem[rd_ptr_r];
	assign level     = cnt_r;

	// storage array
	always_ff @(posedge hclk) begin
		if (push) begin
			mem[wr_ptr_r] <= in_data;
		end
	end

	// pointers and count
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_ptr_r <= '0;
			rd_ptr_r <= '0;
			cnt_r    <= '0;
		end else begin
			if (push) begin
				wr_ptr_r <= (wr_ptr_r == AW'(DEPTH - 1)) ? '0 : wr_ptr_r + 1'b1;
			end
			if (pop) begin
				rd_ptr_r <= (rd_ptr_r == AW'(DEPTH - 1)) ? '0 : rd_ptr_r + 1'b1;
			end
			cnt_r <= cnt_r + (AW+1)'(push) - (AW+1)'(pop);
		end
	end

endmodule : bst_fifo

`default_nettype wire

// ===== core/bst_top.sv
// boundary scan test port: mode control, latch chain, pin drive, bus slave
`timescale 1ns/10ps
`default_nettype none
`include "bst_regs.svh"

////////////////////////////////////////////////////////////////////////////
// How it works
// - select seen active puts the port in scan mode by the next clock
// - select seen inactive drops scan mode on the following clock
// - select and shift-select encode none, reserved, normal and shift
// - shift-select seen active switches to shift sub-mode by the next clock
// - shift-select seen inactive switches to normal sub-mode by the next clock
// - every pin owns a latch: input, output or drive control
// - normal sub-mode drives output latches where their control is set
// - normal sub-mode leaves outputs undriven where control is clear
// - shift entry clock captures the level of every pin not forced into its latch
// - floated pins capture outside levels, forced pins keep latch values
// - right after shift entry the request pin shows its own latch
// - later shift clocks move chain toward request pin, serial in enters
// - shift floats all outputs except hold acknowledge and request
// - chain runs serial in at 1 through data to request at 127
module bst_top #(
	parameter int FIFO_DEPTH = 32,
	parameter int FIFO_WIDTH = 32
) (
	input  wire logic              hclk,         // processor clock
	input  wire logic              hresetn,      // async reset, active low
	input  wire logic              hsel,         // slave select
	input  wire logic [7:0]        haddr,        // byte address
	input  wire logic [1:0]        htrans,       // transfer type
	input  wire logic              hwrite,       // write when high
	input  wire logic [2:0]        hsize,        // word only
	input  wire logic [31:0]       hwdata,       // write data
	input  wire logic              hready,       // bus ready
	output logic                   hreadyout,    // slave ready
	output logic                   hresp,        // always okay
	output logic      [31:0]       hrdata,       // read data
	input  wire logic [126:0]      pin_in,       // pin levels, pos 1 = bit 0
	input  var  bst_pkg::bst_pins_t func_pins,   // core drive outside scan
	output var  bst_pkg::bst_pins_t pins,        // pin drive
	output logic                   capture_room  // fifo can take a word
);

	////////////////////////////////////////////////////////////////////////
	// chain position map

	// index of the drive control latch of a chain bit, or -1 if none
	function automatic int ctl_of(input int i);
		int p;
		p = i + 1;
		ctl_of = -1;
		if (p >= `BST_POS_D0 && p <= `BST_POS_D63)
			ctl_of = `BST_POS_DATA_CTL - 1;
		if (p >= `BST_POS_A31 && p <= `BST_POS_A3)
			ctl_of = `BST_POS_ADDR_CTL - 1;
		if (p == `BST_POS_ROW)
			ctl_of = `BST_POS_ROW_CTL - 1;
		if (p == `BST_POS_PAGE)
			ctl_of = `BST_POS_PAGE_CTL - 1;
		if (p == `BST_POS_DIR)
			ctl_of = `BST_POS_DIR_CTL - 1;
		if (p == `BST_POS_STB)
			ctl_of = `BST_POS_STB_CTL - 1;
		if (p == `BST_POS_LOCK)
			ctl_of = `BST_POS_LOCK_CTL - 1;
		if (p >= `BST_POS_BE_HIGH && p <= `BST_POS_BE_LOW)
			ctl_of = `BST_POS_BE_CTL - 1;
	endfunction : ctl_of

	localparam int HOLD_IDX = `BST_POS_HOLD_ACK - 1;
	localparam int BUS_REQUEST_SERIAL_OUT_IDX = `BST_POS_BUS_REQUEST_SERIAL_OUT - 1;

	////////////////////////////////////////////////////////////////////////
	// pin synchronisers and mode control

	logic [126:0]       pin_s;
	bst_pkg::bst_mode_t mode_r;
	bst_pkg::bst_mode_t mode_nxt;
	logic [126:0]       chain_r;
	logic [126:0]       chain_nxt;
	logic [126:0]       forced;
	logic [126:0]       norm_oe;
	logic [126:0]       cap_val;

	bst_sync #(.WIDTH(`BST_CHAIN_LEN)) u_sync (
		.hclk    (hclk),
		.hresetn (hresetn),
		.d_in    (pin_in),
		.q_out   (pin_s)
	);

	wire sel_s   = pin_s[`BST_POS_SEL - 1];
	wire shift_s = pin_s[`BST_POS_SHIFT - 1];
	wire sin_s   = pin_s[`BST_POS_SIN - 1];

	// mode decode: reserved combination behaves as no test mode
	assign mode_nxt = !sel_s ? bst_pkg::BST_NONE :
		(shift_s ? bst_pkg::BST_SHIFT : bst_pkg::BST_NORMAL);

	wire shift_entry = (mode_nxt == bst_pkg::BST_SHIFT) &&
		(mode_r != bst_pkg::BST_SHIFT);
	wire shift_step  = (mode_nxt == bst_pkg::BST_SHIFT) &&
		(mode_r == bst_pkg::BST_SHIFT);

	// mode register: cleared to no test mode by hresetn
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			mode_r <= bst_pkg::BST_NONE;
		end else begin
			mode_r <= mode_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// drive enables and capture values per chain bit

	genvar gi;
	generate
		for (gi = 0; gi < `BST_CHAIN_LEN; gi++) begin : g_bit
			localparam int CI = ctl_of(gi);
			if (CI >= 0) begin : g_ctl
				assign norm_oe[gi] = chain_r[CI];
			end else if (gi == HOLD_IDX || gi == BUS_REQUEST_SERIAL_OUT_IDX) begin : g_fix
				assign norm_oe[gi] = 1'b1;
			end else begin : g_in
				assign norm_oe[gi] = 1'b0;
			end
		end
	endgenerate

	// a pin forced in normal mode keeps its latch on shift entry
	assign forced  = (mode_r == bst_pkg::BST_NORMAL) ? norm_oe : '0;
	assign cap_val = (forced & chain_r) | (~forced & pin_s);

	// chain next value: capture on entry, shift toward request pin after
	assign chain_nxt = shift_entry ? cap_val :
		(shift_step ? {chain_r[125:0], sin_s} : chain_r);

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			chain_r <= `BST_CHAIN_RST;
		end else begin
			chain_r <= chain_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// pin drive per mode

	logic [126:0] shift_oe;
	assign shift_oe = (127'h1 << HOLD_IDX) | (127'h1 << BUS_REQUEST_SERIAL_OUT_IDX);

	always_comb begin
		case (mode_r)
			bst_pkg::BST_NORMAL: begin
				pins.lvl = chain_r;
				pins.oe  = norm_oe;
			end
			bst_pkg::BST_SHIFT: begin
				pins.lvl = chain_r;
				pins.oe  = shift_oe;
			end
			default: begin
				pins = func_pins;
			end
		endcase
	end

	////////////////////////////////////////////////////////////////////////
	// shifted-out bits packed into words for the fifo

	logic [FIFO_WIDTH-1:0] pack_r;
	logic [4:0]            pack_cnt_r;
	logic                  pack_full_r;
	logic                  fifo_in_ready;
	logic                  fifo_out_valid;
	logic [FIFO_WIDTH-1:0] fifo_out_data;
	logic [$clog2(FIFO_DEPTH):0] fifo_level;
	logic                  cap_en_r;
	logic                  ovf_r;
	logic                  pop;

	wire take_bit = shift_step && cap_en_r;
	wire push     = pack_full_r;

	// collect the request pin bit leaving the chain on each shift clock while capture is enabled
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			pack_r      <= '0;
			pack_cnt_r  <= '0;
			pack_full_r <= 1'b0;
		end else begin
			pack_full_r <= take_bit && (pack_cnt_r == 5'h1f);
			if (take_bit) begin
				pack_r     <= {chain_r[BUS_REQUEST_SERIAL_OUT_IDX], pack_r[FIFO_WIDTH-1:1]};
				pack_cnt_r <= pack_cnt_r + 5'h01;
			end
		end
	end

	bst_fifo #(.WIDTH(FIFO_WIDTH), .DEPTH(FIFO_DEPTH)) u_fifo (
		.hclk      (hclk),
		.hresetn   (hresetn),
		.in_valid  (push),
		.in_ready  (fifo_in_ready),
		.in_data   (pack_r),
		.out_valid (fifo_out_valid),
		.out_ready (pop),
		.out_data  (fifo_out_data),
		.level     (fifo_level)
	);

	assign capture_room = fifo_in_ready;

	////////////////////////////////////////////////////////////////////////
	// ahb-lite slave: one wait state on reads, none on writes

	bst_pkg::bst_aphase_t ap_r;
	logic                 rd_wait_r;
	logic [31:0]          rd_mux;
	logic [31:0]          status;

	wire take   = hsel && htrans[1] && hready;
	wire wr_en  = ap_r.wr;
	wire ctl_wr = wr_en && (ap_r.addr == `BST_CTRL_OFS);
	wire st_wr  = wr_en && (ap_r.addr == `BST_STATUS_OFS);
	wire ovf_clr = st_wr && hwdata[`BST_STAT_OVF_BIT];
	wire ovf_set = push && !fifo_in_ready;

	assign status = (32'(mode_r) << `BST_STAT_MODE_LSB) |
		(32'(ovf_r) << `BST_STAT_OVF_BIT) |
		(32'(fifo_level) << `BST_STAT_LVL_LSB);
	assign rd_mux = (ap_r.addr == `BST_CTRL_OFS)   ? 32'(cap_en_r) :
		(ap_r.addr == `BST_STATUS_OFS) ? status :
		(ap_r.addr == `BST_DATA_OFS && fifo_out_valid) ? fifo_out_data :
		32'h0000_0000;
	assign pop       = rd_wait_r && (ap_r.addr == `BST_DATA_OFS) &&
		fifo_out_valid;
	assign hreadyout = !rd_wait_r;
	assign hresp     = 1'b0;

	// address phase capture and read wait state
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ap_r      <= '0;
			rd_wait_r <= 1'b0;
		end else if (rd_wait_r) begin
			rd_wait_r <= 1'b0;
			ap_r.rd   <= 1'b0;
		end else begin
			ap_r.rd   <= take && !hwrite;
			ap_r.wr   <= take && hwrite;
			ap_r.addr <= haddr;
			rd_wait_r <= take && !hwrite;
		end
	end

	// registers: capture enable, overflow sticky, read data
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			cap_en_r <= 1'(`BST_CTRL_RST);
			ovf_r    <= 1'b0;
			hrdata   <= '0;
		end else begin
			if (ctl_wr) begin
				cap_en_r <= hwdata[`BST_CTRL_CAP_EN_BIT];
			end
			ovf_r <= ovf_set || (ovf_r && !ovf_clr);
			if (rd_wait_r) begin
				hrdata <= rd_mux;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// assertions

	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);

	property p_enter;
		sel_s |=> (mode_r != bst_pkg::BST_NONE);
	endproperty
	a_enter: assert property (p_enter)
		else $error("scan mode not entered after select");

	property p_leave;
		!sel_s |=> (mode_r == bst_pkg::BST_NONE);
	endproperty
	a_leave: assert property (p_leave)
		else $error("scan mode not left after select dropped");

	property p_encode;
		(mode_r == bst_pkg::BST_SHIFT) |-> $past(sel_s) && $past(shift_s);
	endproperty
	a_encode: assert property (p_encode)
		else $error("shift sub-mode without both selects");

	property p_to_shift;
		(sel_s && shift_s) |=> (mode_r == bst_pkg::BST_SHIFT);
	endproperty
	a_to_shift: assert property (p_to_shift)
		else $error("shift sub-mode not taken");

	property p_to_normal;
		(sel_s && !shift_s) |=> (mode_r == bst_pkg::BST_NORMAL);
	endproperty
	a_to_normal: assert property (p_to_normal)
		else $error("normal sub-mode not taken");

	property p_drive;
		(mode_r == bst_pkg::BST_NORMAL && chain_r[4]) |->
			pins.oe[5] && (pins.lvl[5] == chain_r[5]);
	endproperty
	a_drive: assert property (p_drive)
		else $error("enabled data latch not driven");

	property p_float;
		(mode_r == bst_pkg::BST_NORMAL && !chain_r[4]) |-> !pins.oe[5];
	endproperty
	a_float: assert property (p_float)
		else $error("disabled data pin still driven");

	property p_capture;
		shift_entry |=> (chain_r[112] == $past(pin_s[112]));
	endproperty
	a_capture: assert property (p_capture)
		else $error("input latch missed capture");

	property p_keep;
		(shift_entry && mode_r == bst_pkg::BST_NORMAL && chain_r[4]) |=>
			(chain_r[5] == $past(chain_r[5]));
	endproperty
	a_keep: assert property (p_keep)
		else $error("forced latch changed on capture");

	property p_serial_out;
		(mode_r == bst_pkg::BST_SHIFT) |->
			pins.oe[BUS_REQUEST_SERIAL_OUT_IDX] && (pins.lvl[BUS_REQUEST_SERIAL_OUT_IDX] == chain_r[BUS_REQUEST_SERIAL_OUT_IDX]);
	endproperty
	a_serial_out: assert property (p_serial_out)
		else $error("request pin not showing its latch");

	property p_shift;
		shift_step |=> (chain_r[0] == $past(sin_s)) &&
			(chain_r[BUS_REQUEST_SERIAL_OUT_IDX] == $past(chain_r[125]));
	endproperty
	a_shift: assert property (p_shift)
		else $error("chain did not advance");

	property p_quiet;
		(mode_r == bst_pkg::BST_SHIFT) |-> ((pins.oe & ~shift_oe) == '0);
	endproperty
	a_quiet: assert property (p_quiet)
		else $error("output driven during shift");

	property p_pass;
		(mode_r == bst_pkg::BST_NONE) |-> (pins == func_pins);
	endproperty
	a_pass: assert property (p_pass)
		else $error("latches disturb pins outside scan");

endmodule : bst_top

`default_nettype wire

// ===== bench/bst_tester.sv
// tester model: drives the scan command pins and resolves the shared pins
`timescale 1ns/10ps
`default_nettype none

module bst_tester (
	input  wire logic               sel,    // scan select command
	input  wire logic               scan,   // shift select command
	input  wire logic               sin,    // serial bit to the chain
	input  wire logic [126:0]       rest,   // levels on all other pins
	input  var  bst_pkg::bst_pins_t pins,   // device drive and enables
	output logic      [126:0]       pin_in  // level seen on every pin
);
	////////////////////////////////////////////////////////////////////////////
	// tester levels: reset and hold stay high while scanning so that
	// the outputs float wherever the latches do not force them
	wire logic [126:0] tdrv;
	assign tdrv = {rest[126:117], rest[116] | sel, rest[115:4],
		rest[3] | sel, scan, sel, sin};
	// the device wins on every pin it drives, the tester elsewhere
	assign pin_in = (pins.oe & pins.lvl) | (~pins.oe & tdrv);
endmodule : bst_tester

`default_nettype wire

// ===== bench/tb_top.sv
// self-checking bench for the boundary scan test port
`timescale 1ns/10ps
`default_nettype none
`include "bst_regs.svh"

module tb_top;
	localparam logic [126:0] DRV  = 127'h4000_2000_0000_0000_0000_0000_0000_0000;
	localparam logic [126:0] CTLM = 127'h0020_4ab0_0000_0000_0000_0000_0000_0010;
	logic               hclk, hresetn, hsel, hwrite;
	logic               hreadyout, hresp, capture_room;
	logic               sel, scan, sin;
	logic [7:0]         haddr;
	logic [1:0]         htrans;
	logic [31:0]        hwdata, hrdata, rd;
	logic [126:0]       rest, pin_in, prev;
	bst_pkg::bst_pins_t func_pins, pins;
	int                 error_cnt, check_count;

	////////////////////////////////////////////////////////////////////////////
	// far side tester and the device
	bst_tester tst_u (.sel(sel), .scan(scan), .sin(sin), .rest(rest),
		.pins(pins), .pin_in(pin_in));
	bst_top dut_u (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
		.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
		.hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
		.hresp(hresp), .hrdata(hrdata), .pin_in(pin_in),
		.func_pins(func_pins), .pins(pins), .capture_room(capture_room));

	// 25 mhz clock
	initial begin
		hclk = 1'b0;
		forever #20 hclk = ~hclk;
	end

	// compare and count
	task automatic chk(input string n, input logic [126:0] s, e);
		check_count++;
		if (s !== e) begin
			error_cnt++;
			$display("BAD %s exp %h got %h", n, e, s);
		end
	endtask : chk

	// verdict and end of run
	task automatic final_report();
		if (error_cnt == 0 && check_count > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask : final_report

	function automatic logic [126:0] rnd();
		return 127'({$urandom, $urandom, $urandom, $urandom});
	endfunction : rnd

	// expected status word
	function automatic logic [31:0] stat(logic [1:0] m, logic o,
		logic [5:0] l);
		return {18'h0, l, 5'h0, o, m};
	endfunction : stat

	// expected fifo word w: latches leave from position 127 down, then sin
	function automatic logic [31:0] word_exp(int w, logic [126:0] c,
		logic s);
		logic [31:0] r;
		for (int k = 0; k < 32; k++) begin
			if (32 * w + k < 127)
				r[k] = c[126 - 32 * w - k];
			else
				r[k] = s;
		end
		return r;
	endfunction : word_exp

	// forced latches keep their value, all others take the pin level
	function automatic logic cap_exp(int p, logic [126:0] pv, pr);
		if (p == 110 || p == 127 || (pr[4] && p >= 6 && p <= 69))
			return pr[p-1];
		return pv[p-1];
	endfunction : cap_exp

	// single ahb-lite transfer, waits on hready in both phases
	task automatic ahb(input logic w, input logic [7:0] a,
		input logic [31:0] wd);
		hsel <= 1'b1;
		htrans <= 2'h2;
		haddr <= a;
		hwrite <= w;
		@(posedge hclk);
		while (hreadyout !== 1'b1) @(posedge hclk);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= wd;
		@(posedge hclk);
		while (hreadyout !== 1'b1) @(posedge hclk);
		rd = hrdata;
		chk("hresp", hresp, 127'h0);
	endtask : ahb

	task automatic rdchk(input string n, input logic [7:0] a,
		input logic [31:0] e);
		ahb(1'b0, a, 32'h0);
		chk(n, rd, e);
	endtask : rdchk

	// change the command pins, check enables before and after the switch
	task automatic mode_step(input logic s, c, input logic [126:0] b, a);
		@(posedge hclk);
		sel <= s;
		scan <= c;
		repeat (2) @(posedge hclk);
		@(negedge hclk);
		chk("oe before", pins.oe, b);
		@(negedge hclk);
		chk("oe after", pins.oe, a);
	endtask : mode_step

	// enter shift from normal, read the captured chain, load nd, leave
	task automatic do_shift(input logic [126:0] nd);
		logic [126:0] pv;
		int           p;
		pv = rnd();
		pv[3] = 1'b1;
		pv[116] = 1'b1;
		pv[2:1] = 2'h3;
		for (int j = 0; j <= 133; j++) begin
			@(posedge hclk);
			if (j == 0) begin
				rest <= pv;
				scan <= 1'b1;
			end
			if (j == 130)
				scan <= 1'b0;
			sin <= (j >= 3 && j <= 129) ? nd[129-j] : 1'($urandom);
			@(negedge hclk);
			p = 130 - j;
			if (j >= 3 && j <= 129 && p != 1 && !CTLM[p-1])
				chk("capture", pins.lvl[126], cap_exp(p, pv, prev));
			if (j >= 3 && j <= 132)
				chk("shift oe", pins.oe, DRV);
		end
		prev = nd;
	endtask : do_shift

	// normal sub-mode drives hold acknowledge, request and the latches whose control is set
	task automatic normal_chk();
		logic [126:0] oe;
		oe = DRV | (prev[4] ? {58'h0, {64{1'b1}}, 5'h0} : 127'h0);
		chk("normal oe", pins.oe, oe);
		chk("normal lvl", pins.lvl & oe, prev & oe);
	endtask : normal_chk

	// hang guard
	initial begin
		repeat (20000) @(posedge hclk);
		error_cnt++;
		final_report();
	end

	////////////////////////////////////////////////////////////////////////////
	// main sequence
	initial begin
		logic [126:0] d;
		logic [126:0] c;
		hresetn = 1'b0;
		hsel = 1'b0;
		haddr = 8'h0;
		htrans = 2'h0;
		hwrite = 1'b0;
		hwdata = 32'h0;
		sel = 1'b0;
		scan = 1'b0;
		sin = 1'b0;
		rest = 127'h0;
		prev = 127'h0;
		error_cnt = 0;
		check_count = 0;
		void'($urandom(32'he245));
		func_pins.lvl = rnd();
		func_pins.oe = rnd() & ~127'hf;
		repeat (10) @(posedge hclk);
		hresetn <= 1'b1;
		@(negedge hclk);
		chk("idle oe", pins.oe, func_pins.oe);
		chk("idle lvl", pins.lvl, func_pins.lvl);
		@(posedge hclk);
		rdchk("ctrl rst", `BST_CTRL_OFS, `BST_CTRL_RST);
		rdchk("status rst", `BST_STATUS_OFS, stat(2'h0, 1'b0, 6'h0));
		ahb(1'b1, 8'hfc, 32'hffff_ffff);
		rdchk("unmapped", 8'hfc, 32'h0);
		mode_step(1'b0, 1'b1, func_pins.oe, func_pins.oe);
		mode_step(1'b1, 1'b0, func_pins.oe, DRV);
		@(posedge hclk);
		rdchk("status normal", `BST_STATUS_OFS, stat(2'h1, 1'b0, 6'h0));
		// shift in with data drive on, force, then shift out again
		d = rnd() & ~CTLM;
		d[4] = 1'b1;
		do_shift(d);
		normal_chk();
		d = rnd() & ~CTLM;
		do_shift(d);
		normal_chk();
		mode_step(1'b0, 1'b0, DRV, func_pins.oe);
		// state is undefined after scan, so the tester resets
		@(posedge hclk);
		hresetn <= 1'b0;
		repeat (2) @(posedge hclk);
		hresetn <= 1'b1;
		prev = 127'h0;
		@(posedge hclk);
		// fill the fifo from the shift stream while the reader stalls
		ahb(1'b1, `BST_CTRL_OFS, 32'h1);
		rdchk("ctrl", `BST_CTRL_OFS, 32'h1);
		// pin levels the latches take when shift starts from no test mode
		c = rest;
		c[3:0] = {3'h7, sin};
		c[116] = 1'b1;
		c = (func_pins.oe & func_pins.lvl) | (~func_pins.oe & c);
		mode_step(1'b1, 1'b1, func_pins.oe, DRV);
		repeat (1100) @(posedge hclk);
		rdchk("status full", `BST_STATUS_OFS, stat(2'h2, 1'b1, 6'd32));
		chk("room full", capture_room, 127'h0);
		mode_step(1'b0, 1'b0, DRV, func_pins.oe);
		@(posedge hclk);
		ahb(1'b1, `BST_STATUS_OFS, 32'h4);
		rdchk("status clr", `BST_STATUS_OFS, stat(2'h0, 1'b0, 6'd32));
		for (int i = 0; i < 32; i++)
			rdchk("fifo", `BST_DATA_OFS, word_exp(i, c, sin));
		rdchk("status empty", `BST_STATUS_OFS, stat(2'h0, 1'b0, 6'h0));
		chk("room empty", capture_room, 127'h1);
		rdchk("data empty", `BST_DATA_OFS, 32'h0);
		final_report();
	end
endmodule : tb_top

`default_nettype wire
